// ---- test/xcv_card_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module xcv_card_model (
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] a_out,
    input wire logic a_oe,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] b_out,
    input wire logic b_oe,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] a_src,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] b_src,
    input wire logic b_idle,
    output logic [xcv_pkg::XCV_WIDTH-1:0] a_wire,
    output logic [xcv_pkg::XCV_WIDTH-1:0] b_wire
);
    // card logic turns around as soon as the device drives, so no contention
    assign a_wire = a_oe ? a_out : a_src;
    // an idle backplane floats up to the termination level
    assign b_wire = b_oe ? b_out : (b_idle ? '1 : b_src);
endmodule : xcv_card_model

`default_nettype wire

// ---- test/xcv_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none

module xcv_top_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic a_to_b_output_enable_n,
    input wire logic a_to_b_latch_enable,
    input wire logic a_to_b_clock,
    input wire logic a_to_b_clock_enable_n,
    input wire logic b_to_a_output_enable_n,
    input wire logic b_to_a_latch_enable,
    input wire logic b_to_a_clock,
    input wire logic b_to_a_clock_enable_n,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] a_in,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] a_out,
    input wire logic a_oe,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] b_in,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] b_out,
    input wire logic b_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    ab_isolate_a: assert property (1 |=> b_oe == !$past(a_to_b_output_enable_n))
        else $error("b drive enable does not follow its output enable");
    ba_isolate_a: assert property (1 |=> a_oe == !$past(b_to_a_output_enable_n))
        else $error("a drive enable does not follow its output enable");
    ab_follow_a: assert property (a_to_b_latch_enable |=> b_out == $past(a_in))
        else $error("b output not transparent to a input");
    ba_follow_a: assert property (b_to_a_latch_enable |=> a_out == $past(b_in))
        else $error("a output not transparent to b input");
    // edge memory restarts high after reset, hence the guard on the past reset
    ab_capture_a: assert property ($past(rst_n) && !a_to_b_latch_enable
        && !a_to_b_clock_enable_n && $rose(a_to_b_clock) |=> b_out == $past(a_in))
        else $error("a to b clock edge did not capture a input");
    ba_capture_a: assert property ($past(rst_n) && !b_to_a_latch_enable
        && !b_to_a_clock_enable_n && $rose(b_to_a_clock) |=> a_out == $past(b_in))
        else $error("b to a clock edge did not capture b input");
    ab_hold_a: assert property ($past(rst_n) && !a_to_b_latch_enable
        && (a_to_b_clock_enable_n || !$rose(a_to_b_clock)) |=> $stable(b_out))
        else $error("b stored value changed without a capture");
    ba_hold_a: assert property ($past(rst_n) && !b_to_a_latch_enable
        && (b_to_a_clock_enable_n || !$rose(b_to_a_clock)) |=> $stable(a_out))
        else $error("a stored value changed without a capture");
    read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read data phase is not one wait state");
endmodule : xcv_top_chk

bind xcv_top xcv_top_chk u_chk (.clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .a_to_b_output_enable_n, .a_to_b_latch_enable, .a_to_b_clock, .a_to_b_clock_enable_n,
    .b_to_a_output_enable_n, .b_to_a_latch_enable, .b_to_a_clock, .b_to_a_clock_enable_n,
    .a_in, .a_out, .a_oe, .b_in, .b_out, .b_oe);

`default_nettype wire

// ---- test/xcv_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module xcv_top_tb;
    import xcv_pkg::*;
    localparam int W = XCV_WIDTH;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    xcv_ctl_s ab = '{oe_n: 1'b1, le: 1'b0, clk: 1'b1, ce_n: 1'b1};
    xcv_ctl_s ba = '{oe_n: 1'b1, le: 1'b0, clk: 1'b1, ce_n: 1'b1};
    logic [W-1:0] a_src = '0;
    logic [W-1:0] b_src = '0;
    logic b_idle = 1'b1;
    logic [W-1:0] a_wire, b_wire, a_out, b_out;
    logic a_oe, b_oe;
    logic [31:0] rd;
    logic [W-1:0] vals [3] = '{18'h0f0f0, 18'h30303, 18'h0a5a5};
    int bad_count = 0;
    int checked = 0;

    xcv_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .a_to_b_output_enable_n(ab.oe_n), .a_to_b_latch_enable(ab.le),
        .a_to_b_clock(ab.clk), .a_to_b_clock_enable_n(ab.ce_n),
        .b_to_a_output_enable_n(ba.oe_n), .b_to_a_latch_enable(ba.le),
        .b_to_a_clock(ba.clk), .b_to_a_clock_enable_n(ba.ce_n),
        .a_in(a_wire), .a_out(a_out), .a_oe(a_oe), .b_in(b_wire), .b_out(b_out), .b_oe(b_oe));

    xcv_card_model u_card (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .a_src(a_src), .b_src(b_src), .b_idle(b_idle), .a_wire(a_wire), .b_wire(b_wire));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // looks at hready before the edge that samples it, so no race with the flops
    task automatic wt;
        int n = 0;
        do begin
            @(negedge clk);
            rd = hrdata;
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        // ready seen on the last try is not a timeout
        if (hreadyout !== 1'b1) begin
            bad_count++;
            give_verdict();
        end else begin
            @(posedge clk);
        end
    endtask : wt

    task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, off};
        hwrite <= wr;
        wt();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wt();
    endtask : bus

    task automatic rdc(input logic [7:0] off, input logic [31:0] exp);
        bus(1'b0, off, '0);
        chk($sformatf("register %h", off), rd, exp);
        chk("hresp", hresp, {31'h0, HRESP_OKAY});
    endtask : rdc

    task automatic mode(input bit on_ba, input xcv_mode_e m);
        bus(1'b0, XCV_OFF_STATUS, '0);
        chk("mode", on_ba ? rd[12:8] : rd[4:0], m);
    endtask : mode

    task automatic see(input bit on_b, input logic [W-1:0] exp);
        @(negedge clk);
        chk(on_b ? "b_wire" : "a_wire", on_b ? b_wire : a_wire, exp);
        @(posedge clk);
    endtask : see

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    initial begin
        forever #5 clk = ~clk;
    end

    initial begin
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
        rdc(XCV_OFF_CTRL, XCV_CTRL_RST);
        rdc(8'h40, 32'h0);
        // select bits left clear so the pins keep control
        bus(1'b1, XCV_OFF_CTRL, 32'hffff_fffc);
        rdc(XCV_OFF_CTRL, XCV_CTRL_MASK & 32'hffff_fffc);
        bus(1'b1, XCV_OFF_CTRL, XCV_CTRL_RST);
        ab.le <= 1'b1;
        a_src <= 18'h12345;
        cyc(2);
        see(1'b1, '1);
        mode(1'b0, XCV_ISOLATE);
        ab.oe_n <= 1'b0;
        a_src <= 18'h2a5a5;
        cyc(2);
        see(1'b1, 18'h2a5a5);
        a_src <= 18'h15a5a;
        cyc(1);
        see(1'b1, 18'h15a5a);
        mode(1'b0, XCV_TRANSPARENT);
        ab.le <= 1'b0;
        ab.ce_n <= 1'b0;
        cyc(1);
        a_src <= 18'h3ffff;
        cyc(2);
        see(1'b1, 18'h15a5a);
        mode(1'b0, XCV_LATCHED);
        for (int i = 0; i < 3; i++) begin
            ab.clk <= 1'b0;
            cyc(1);
            a_src <= vals[i];
            ab.clk <= 1'b1;
            // the read's address edge is the capture edge, so status shows the edge
            mode(1'b0, XCV_CLOCKED);
            a_src <= ~vals[i];
            cyc(1);
            see(1'b1, vals[i]);
        end
        rdc(XCV_OFF_AB_STORE, {14'h0, vals[2]});
        ab.ce_n <= 1'b1;
        ab.clk <= 1'b0;
        cyc(1);
        a_src <= 18'h00abc;
        ab.clk <= 1'b1;
        cyc(2);
        see(1'b1, vals[2]);
        mode(1'b0, XCV_INHIBIT);
        ab.oe_n <= 1'b1;
        cyc(2);
        see(1'b1, '1);
        rdc(XCV_OFF_AB_COUNT, 32'h3);
        bus(1'b1, XCV_OFF_AB_COUNT, 32'h0);
        rdc(XCV_OFF_AB_COUNT, 32'h0);
        b_idle <= 1'b0;
        b_src <= 18'h2d2d2;
        ba <= '{oe_n: 1'b0, le: 1'b0, clk: 1'b0, ce_n: 1'b0};
        cyc(1);
        ba.clk <= 1'b1;
        cyc(1);
        b_src <= 18'h01111;
        cyc(1);
        see(1'b0, 18'h2d2d2);
        rdc(XCV_OFF_AB_STORE, {14'h0, vals[2]});
        rdc(XCV_OFF_BA_COUNT, 32'h1);
        ba.le <= 1'b1;
        cyc(1);
        see(1'b0, 18'h01111);
        ba.oe_n <= 1'b1;
        cyc(2);
        see(1'b0, 18'h00abc);
        mode(1'b1, XCV_ISOLATE);
        // software fields differ from the pins only in the clock bit, behaviour unchanged
        bus(1'b0, XCV_OFF_STATUS, '0);
        chk("ab pin ctl", rd[XCV_STAT_AB_CTL_LSB +: XCV_CTL_W], 32'hb);
        bus(1'b1, XCV_OFF_CTRL, 32'h0000_0991);
        bus(1'b0, XCV_OFF_STATUS, '0);
        chk("ab soft ctl", rd[XCV_STAT_AB_CTL_LSB +: XCV_CTL_W], 32'h9);
        give_verdict();
    end
endmodule : xcv_top_tb

`default_nettype wire

// ---- verilog/xcv_event_count.sv ----
`timescale 1ns/1ps
`default_nettype none

module xcv_event_count #(
    parameter int WIDTH = xcv_pkg::XCV_COUNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inc,
    input wire logic clr,
    output logic [WIDTH-1:0] count
);
    import xcv_pkg::*;

    logic [WIDTH-1:0] count_q;

    // saturates rather than wraps so software never sees a false small value
    wire at_max = &count_q;
    wire [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
    // an event in the clearing cycle is kept
    wire [WIDTH-1:0] count_d = clr ? (inc ? one : '0) :
                               (inc & ~at_max) ? count_q + one :
                               count_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

    assign count = count_q;

endmodule : xcv_event_count

`default_nettype wire

// ---- verilog/xcv_path.sv ----
`timescale 1ns/1ps
`default_nettype none

module xcv_path #(
    parameter int WIDTH = xcv_pkg::XCV_WIDTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire xcv_pkg::xcv_ctl_s ctl,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout,
    output logic drive,
    output xcv_pkg::xcv_mode_e mode,
    output logic capture
);
    import xcv_pkg::*;

    logic clk_prev_q;
    logic [WIDTH-1:0] store_q;
    logic drive_q;
    xcv_mode_e mode_q;
    logic capture_q;

    // prev resets high so a clock pin already high at release is no edge
    wire rise = ctl.clk & ~clk_prev_q;
    wire load_latch = ctl.le;
    wire load_clock = ~ctl.le & ~ctl.ce_n & rise;
    // a closed latch with no qualified edge keeps whatever was last loaded
    wire [WIDTH-1:0] store_d = (load_latch | load_clock) ? din : store_q;
    // storage keeps working while isolated; only the drive is cut
    wire drive_d = ~ctl.oe_n;

    xcv_mode_e mode_d;
    assign mode_d = ctl.oe_n ? XCV_ISOLATE :
                    ctl.le ? XCV_TRANSPARENT :
                    ctl.ce_n ? XCV_INHIBIT :
                    rise ? XCV_CLOCKED :
                    XCV_LATCHED;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_q <= 1'b1;
            store_q <= '0;
            drive_q <= 1'b0;
            mode_q <= XCV_ISOLATE;
            capture_q <= 1'b0;
        end else begin
            clk_prev_q <= ctl.clk;
            store_q <= store_d;
            drive_q <= drive_d;
            mode_q <= mode_d;
            capture_q <= load_clock;
        end
    end

    assign dout = store_q;
    assign drive = drive_q;
    assign mode = mode_q;
    assign capture = capture_q;

endmodule : xcv_path

`default_nettype wire

// ---- verilog/xcv_top.sv ----
// Our own choices: the register addresses and the AHB-Lite register port.
package xcv_pkg;

    // data path width of each direction
    localparam int XCV_WIDTH = 18;
    localparam int XCV_COUNT_W = 16;
    localparam int XCV_DIRS = 2;
    localparam int XCV_DIR_AB = 0;
    localparam int XCV_DIR_BA = 1;

    // register byte offsets
    localparam logic [7:0] XCV_OFF_CTRL = 8'h00;
    localparam logic [7:0] XCV_OFF_STATUS = 8'h04;
    localparam logic [7:0] XCV_OFF_AB_STORE = 8'h08;
    localparam logic [7:0] XCV_OFF_BA_STORE = 8'h0c;
    localparam logic [7:0] XCV_OFF_AB_COUNT = 8'h10;
    localparam logic [7:0] XCV_OFF_BA_COUNT = 8'h14;

    // control register fields
    localparam int XCV_CTRL_AB_SEL = 0;
    localparam int XCV_CTRL_BA_SEL = 1;
    localparam int XCV_CTRL_AB_CTL_LSB = 4;
    localparam int XCV_CTRL_BA_CTL_LSB = 8;
    localparam int XCV_CTL_W = 4;
    localparam logic [31:0] XCV_CTRL_MASK = 32'h0000_0ff3;
    // software controls reset to isolated, clock inhibited
    localparam logic [31:0] XCV_CTRL_RST = 32'h0000_0990;

    // status register fields
    localparam int XCV_STAT_AB_MODE_LSB = 0;
    localparam int XCV_STAT_BA_MODE_LSB = 8;
    localparam int XCV_STAT_AB_DRIVE = 16;
    localparam int XCV_STAT_BA_DRIVE = 17;
    localparam int XCV_STAT_AB_CTL_LSB = 20;
    localparam int XCV_STAT_BA_CTL_LSB = 24;

    // ahb-lite encodings
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic oe_n;
        logic le;
        logic clk;
        logic ce_n;
    } xcv_ctl_s;

    typedef enum logic [4:0] {
        XCV_ISOLATE = 5'h01,
        XCV_TRANSPARENT = 5'h02,
        XCV_CLOCKED = 5'h04,
        XCV_LATCHED = 5'h08,
        XCV_INHIBIT = 5'h10
    } xcv_mode_e;

    function automatic logic xcv_hit(input logic [31:0] addr, input logic [7:0] off);
        return (addr[31:8] == 24'h00_0000) && (addr[7:2] == off[7:2]);
    endfunction : xcv_hit

endpackage : xcv_pkg

`timescale 1ns/1ps
`default_nettype none

module xcv_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic a_to_b_output_enable_n,
    input wire logic a_to_b_latch_enable,
    input wire logic a_to_b_clock,
    input wire logic a_to_b_clock_enable_n,
    input wire logic b_to_a_output_enable_n,
    input wire logic b_to_a_latch_enable,
    input wire logic b_to_a_clock,
    input wire logic b_to_a_clock_enable_n,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] a_in,
    output logic [xcv_pkg::XCV_WIDTH-1:0] a_out,
    output logic a_oe,
    input wire logic [xcv_pkg::XCV_WIDTH-1:0] b_in,
    output logic [xcv_pkg::XCV_WIDTH-1:0] b_out,
    output logic b_oe
);
    import xcv_pkg::*;

    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic wr_pend_q;
    logic [31:0] wr_addr_q;
    logic rd_wait_q;
    logic [31:0] rd_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    xcv_ctl_s ctl_pin [XCV_DIRS];
    xcv_ctl_s ctl_eff [XCV_DIRS];
    logic sw_sel [XCV_DIRS];
    logic [XCV_WIDTH-1:0] dir_in [XCV_DIRS];
    logic [XCV_WIDTH-1:0] dir_out [XCV_DIRS];
    logic dir_drive [XCV_DIRS];
    xcv_mode_e dir_mode [XCV_DIRS];
    logic dir_capture [XCV_DIRS];
    logic cnt_clr [XCV_DIRS];
    logic [XCV_COUNT_W-1:0] cnt_val [XCV_DIRS];

    // bus request decode
    wire addr_phase = hsel & htrans[1] & hready;
    wire wr_take = addr_phase & hwrite;
    wire rd_take = addr_phase & ~hwrite;
    wire wr_ctrl = wr_pend_q & xcv_hit(wr_addr_q, XCV_OFF_CTRL);
    wire wr_ab_count = wr_pend_q & xcv_hit(wr_addr_q, XCV_OFF_AB_COUNT);
    wire wr_ba_count = wr_pend_q & xcv_hit(wr_addr_q, XCV_OFF_BA_COUNT);

    assign ctrl_d = wr_ctrl ? (hwdata & XCV_CTRL_MASK) : ctrl_q;

    // pin controls per direction
    assign ctl_pin[XCV_DIR_AB] = '{oe_n: a_to_b_output_enable_n, le: a_to_b_latch_enable,
                                   clk: a_to_b_clock, ce_n: a_to_b_clock_enable_n};
    assign ctl_pin[XCV_DIR_BA] = '{oe_n: b_to_a_output_enable_n, le: b_to_a_latch_enable,
                                   clk: b_to_a_clock, ce_n: b_to_a_clock_enable_n};
    assign sw_sel[XCV_DIR_AB] = ctrl_q[XCV_CTRL_AB_SEL];
    assign sw_sel[XCV_DIR_BA] = ctrl_q[XCV_CTRL_BA_SEL];
    assign dir_in[XCV_DIR_AB] = a_in;
    assign dir_in[XCV_DIR_BA] = b_in;
    assign cnt_clr[XCV_DIR_AB] = wr_ab_count;
    assign cnt_clr[XCV_DIR_BA] = wr_ba_count;

    // software fields take over from the pins only while selected
    assign ctl_eff[XCV_DIR_AB] = sw_sel[XCV_DIR_AB] ?
        xcv_ctl_s'(ctrl_q[XCV_CTRL_AB_CTL_LSB +: XCV_CTL_W]) : ctl_pin[XCV_DIR_AB];
    assign ctl_eff[XCV_DIR_BA] = sw_sel[XCV_DIR_BA] ?
        xcv_ctl_s'(ctrl_q[XCV_CTRL_BA_CTL_LSB +: XCV_CTL_W]) : ctl_pin[XCV_DIR_BA];

    // both directions are identical, own storage each
    genvar g;
    generate
        for (g = 0; g < XCV_DIRS; g++) begin : g_dir
            xcv_path #(
                .WIDTH(XCV_WIDTH)
            ) u_path (
                .clk(clk),
                .rst_n(rst_n),
                .ctl(ctl_eff[g]),
                .din(dir_in[g]),
                .dout(dir_out[g]),
                .drive(dir_drive[g]),
                .mode(dir_mode[g]),
                .capture(dir_capture[g])
            );

            xcv_event_count #(
                .WIDTH(XCV_COUNT_W)
            ) u_count (
                .clk(clk),
                .rst_n(rst_n),
                .inc(dir_capture[g]),
                .clr(cnt_clr[g]),
                .count(cnt_val[g])
            );
        end
    endgenerate

    assign b_out = dir_out[XCV_DIR_AB];
    assign b_oe = dir_drive[XCV_DIR_AB];
    assign a_out = dir_out[XCV_DIR_BA];
    assign a_oe = dir_drive[XCV_DIR_BA];

    // status word
    logic [31:0] status_w;
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[XCV_STAT_AB_MODE_LSB +: 5] = dir_mode[XCV_DIR_AB];
        status_w[XCV_STAT_BA_MODE_LSB +: 5] = dir_mode[XCV_DIR_BA];
        status_w[XCV_STAT_AB_DRIVE] = dir_drive[XCV_DIR_AB];
        status_w[XCV_STAT_BA_DRIVE] = dir_drive[XCV_DIR_BA];
        status_w[XCV_STAT_AB_CTL_LSB +: XCV_CTL_W] = ctl_eff[XCV_DIR_AB];
        status_w[XCV_STAT_BA_CTL_LSB +: XCV_CTL_W] = ctl_eff[XCV_DIR_BA];
    end

    localparam int PAD_DATA = 32 - XCV_WIDTH;
    localparam int PAD_CNT = 32 - XCV_COUNT_W;

    wire hit_ctrl = xcv_hit(rd_addr_q, XCV_OFF_CTRL);
    wire hit_status = xcv_hit(rd_addr_q, XCV_OFF_STATUS);
    wire hit_ab_store = xcv_hit(rd_addr_q, XCV_OFF_AB_STORE);
    wire hit_ba_store = xcv_hit(rd_addr_q, XCV_OFF_BA_STORE);
    wire hit_ab_count = xcv_hit(rd_addr_q, XCV_OFF_AB_COUNT);
    wire hit_ba_count = xcv_hit(rd_addr_q, XCV_OFF_BA_COUNT);

    // unmapped offsets read as zero
    wire [31:0] rd_val =
        hit_ctrl ? ctrl_q :
        hit_status ? status_w :
        hit_ab_store ? {{PAD_DATA{1'b0}}, dir_out[XCV_DIR_AB]} :
        hit_ba_store ? {{PAD_DATA{1'b0}}, dir_out[XCV_DIR_BA]} :
        hit_ab_count ? {{PAD_CNT{1'b0}}, cnt_val[XCV_DIR_AB]} :
        hit_ba_count ? {{PAD_CNT{1'b0}}, cnt_val[XCV_DIR_BA]} :
        32'h0000_0000;

    // a read waits one cycle so a write just ahead of it is already visible
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
            rd_wait_q <= 1'b0;
            rd_addr_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= wr_take;
            rd_wait_q <= rd_take;
            if (wr_take) begin
                wr_addr_q <= haddr;
            end
            if (rd_take) begin
                rd_addr_q <= haddr;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hreadyout_q <= 1'b1;
            hrdata_q <= 32'h0000_0000;
            hresp_q <= HRESP_OKAY;
        end else begin
            hreadyout_q <= ~rd_take;
            hresp_q <= HRESP_OKAY;
            if (rd_wait_q) begin
                hrdata_q <= rd_val;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= XCV_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hrdata = hrdata_q;
    assign hresp = hresp_q;

    // hsize is not checked: only whole-word transfers are issued
    wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule : xcv_top

`default_nettype wire
